// *** hw/etc_core.sv ***
// trace capture core: sampling, triggering, buffer and wishbone registers
//
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
module etc_core #(
   parameter int DEPTH   = 64,                      // trace buffer samples
   parameter int TRACE_W = 32,                      // trace signals
   parameter int NUM_TU  = 2,                       // trigger units
   parameter int TU_W    = 8,                       // signals per unit
   parameter bit INCL_TRIG = 1'b1,                  // store trigger signals too
   parameter bit TS_EN   = 1'b1,                    // timestamp present
   parameter int TS_W    = 16,                      // timestamp width
   parameter bit SE_EN   = 1'b1,                    // sample enable present
   parameter bit SE_HIGH = 1'b1,                    // enable active high
   parameter bit MULTI   = 1'b1,                    // multiple trigger capture
   parameter int MIN_SPT = 16,                      // least samples per trigger
   parameter int SER_LEN = 4                        // serial pattern length
) (
   input  wire logic                      clk_i,    // core clock
   input  wire logic                      rst_i,    // synchronous reset
   input  wire logic                      cyc_i,    // wishbone cycle
   input  wire logic                      stb_i,    // wishbone strobe
   input  wire logic                      we_i,     // write
   input  wire logic [etc_pkg::WB_AW-1:0] adr_i,    // byte address
   input  wire logic [etc_pkg::WB_SW-1:0] sel_i,    // byte enables
   input  wire logic [etc_pkg::WB_DW-1:0] dat_i,    // write data
   output logic      [etc_pkg::WB_DW-1:0] dat_o,    // read data
   output logic                           ack_o,    // acknowledge
   input  wire logic                      smp_clk_i,  // sample clock
   input  wire logic                      sen_i,      // sample enable
   input  wire logic [TRACE_W-1:0]        trace_i,    // traced signals
   input  wire logic [NUM_TU*TU_W-1:0]    trig_i      // trigger unit signals
);
   import etc_pkg::*;
   localparam int AW   = $clog2(DEPTH);             // buffer address width
   localparam int TGW  = NUM_TU*TU_W;               // trigger signal bits
   localparam int W    = (TS_EN ? TS_W : 0) + (INCL_TRIG ? TGW : 0) + TRACE_W;
   localparam int WP   = ((W+31)/32)*32;            // word padded to bus words
   localparam int VP   = ((TU_W+31)/32)*32;         // unit value padded
   localparam int NSEG = MULTI ? DEPTH/MIN_SPT : 1; // most segments
   localparam logic [AW+1:0] DEPTH_L = (AW+2)'(DEPTH);
   localparam logic [AW:0]   MIN_L   = (AW+1)'(MIN_SPT);

   // input synchronisers, two stages each
   logic               sclk_s1, sclk_s2, sclk_s3;   // sample clock chain
   logic               sen_s1, sen_s2;              // enable chain
   logic [TRACE_W-1:0] tr_s1, tr_s2;                // trace chain
   logic [TGW-1:0]     tg_s1, tg_s2;                // trigger chain
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
         {sen_s1, sen_s2} <= 2'h0;
         tr_s1 <= '0;
         tr_s2 <= '0;
         tg_s1 <= '0;
         tg_s2 <= '0;
      end else begin
         sclk_s1 <= smp_clk_i;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;                        // edge history only
         sen_s1  <= sen_i;
         sen_s2  <= sen_s1;
         tr_s1   <= trace_i;
         tr_s2   <= tr_s1;
         tg_s1   <= trig_i;
         tg_s2   <= tg_s1;
      end
   end
   logic smp_stb;                                   // sample clock rose
   logic en_ok;                                     // enable allows storing
   assign smp_stb = sclk_s2 & ~sclk_s3;
   assign en_ok   = !SE_EN || (sen_s2 == SE_HIGH);

   // wishbone handshake, answer one cycle after the request
   logic ack_ff;                                    // ack register
   logic req, wr;                                   // new request, write
   assign req   = cyc_i & stb_i & ~ack_ff;
   assign wr    = req & we_i;
   assign ack_o = ack_ff;
   always_ff @(posedge clk_i) begin
      if (rst_i) ack_ff <= 1'b0;
      else ack_ff <= req;
   end
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      return (old & ~m) | (nw & m);
   endfunction

   // software registers
   logic [31:0]       spt_ff, post_ff, tuen_ff, tusel_ff, rdadr_ff, rdwsl_ff;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         spt_ff   <= 32'(MIN_SPT);
         post_ff  <= '0;
         tuen_ff  <= '0;
         tusel_ff <= '0;
         rdadr_ff <= '0;
         rdwsl_ff <= '0;
      end else if (wr) begin
         unique case (adr_i)
            REG_SPT:    spt_ff   <= merge(spt_ff, dat_i, sel_i);
            REG_POST:   post_ff  <= merge(post_ff, dat_i, sel_i);
            REG_TU_EN:  tuen_ff  <= merge(tuen_ff, dat_i, sel_i);
            REG_TU_SEL: tusel_ff <= merge(tusel_ff, dat_i, sel_i);
            REG_RD_ADR: rdadr_ff <= merge(rdadr_ff, dat_i, sel_i);
            REG_RD_WSL: rdwsl_ff <= merge(rdwsl_ff, dat_i, sel_i);
            default: ;                              // ctrl, unit op and value handled elsewhere, others ignored
         endcase
      end
   end
   logic [SEL_W-1:0] sel_unit, sel_word;            // selected unit and word
   assign sel_unit = tusel_ff[SEL_W-1:0];
   assign sel_word = tusel_ff[SEL_WORD_LSB +: SEL_W];
   logic arm, abort;                                // control strobes
   assign arm   = wr && adr_i == REG_CTRL && sel_i[0] && dat_i[CTRL_ARM];
   assign abort = wr && adr_i == REG_CTRL && sel_i[0] && dat_i[CTRL_ABORT];

   // trigger units, registers and comparators per unit
   logic [NUM_TU-1:0] tu_hit;                       // unit results
   etc_op_t           op_ff  [NUM_TU];              // unit operators
   logic [VP-1:0]     val_ff [NUM_TU];              // unit values
   genvar g;
   generate
      for (g = 0; g < NUM_TU; g++) begin : g_tu
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               op_ff[g]  <= OP_EQ;
               val_ff[g] <= '0;
            end else if (wr && sel_unit == SEL_W'(g)) begin
               if (adr_i == REG_TU_OP && sel_i[0])
                  op_ff[g] <= etc_op_t'(dat_i[OPW-1:0]);
               if (adr_i == REG_TU_VAL && int'(sel_word) < VP/32)
                  val_ff[g][sel_word*32 +: 32] <= merge(val_ff[g][sel_word*32 +: 32],
                                                        dat_i, sel_i);
            end
         end
         etc_trig_unit #(.W(TU_W), .SER_LEN(SER_LEN)) u_tu (
            .clk_i     (clk_i),
            .rst_i     (rst_i),
            .smp_stb_i (smp_stb),
            .sig_i     (tg_s2[g*TU_W +: TU_W]),
            .op_i      (op_ff[g]),
            .val_i     (val_ff[g][TU_W-1:0]),
            .hit_o     (tu_hit[g])
         );
      end
   endgenerate
   logic hit;                                       // any enabled unit true
   assign hit = |(tu_hit & tuen_ff[NUM_TU-1:0]);

   // stored word: timestamp on top, trigger signals, trace signals low
   logic [W-1:0]    word;
   logic [TS_W-1:0] ts_ff;                          // run timestamp, cleared on arm
   assign word[TRACE_W-1:0] = tr_s2;
   generate
      if (INCL_TRIG) begin : g_incl
         assign word[TRACE_W +: TGW] = tg_s2;
      end
      if (TS_EN) begin : g_ts
         assign word[W-1 -: TS_W] = ts_ff;
      end
   endgenerate

   // capture sequencing
   etc_st_t          st_ff;                         // capture state
   logic [AW:0]      base_ff, off_ff, seg_ff;       // segment base, offset, size
   logic [AW:0]      post_left_ff;                  // samples still to keep
   logic [AW:0]      sidx_ff;                       // sample index in segment
   logic [CNT_W-1:0] nseg_ff;                       // segments finished
   logic [AW:0]      tpos_ff [NSEG];                // trigger buffer address
   logic             tapx_ff [NSEG];                // position approximate
   logic [W-1:0]     mem [DEPTH];                   // trace buffer
   logic [AW-1:0]    waddr;                         // write address
   logic             run, store, seg_end, last_seg; // run flags
   logic [AW+1:0]    next_top;                      // end of following segment
   logic [AW:0]      spt_clamp;                     // legal samples per trigger
   assign run      = (st_ff == ST_PRE) || (st_ff == ST_POST);
   assign store    = smp_stb && run && en_ok;
   assign waddr    = AW'(base_ff + off_ff);
   assign seg_end  = smp_stb && st_ff == ST_POST && post_left_ff == '0;
   assign next_top = (AW+2)'(base_ff) + ((AW+2)'(seg_ff) << 1);
   assign last_seg = !MULTI || next_top > DEPTH_L;
   always_comb begin
      if (spt_ff < 32'(MIN_L)) spt_clamp = MIN_L;
      else if (spt_ff > 32'(DEPTH)) spt_clamp = (AW+1)'(DEPTH);
      else spt_clamp = spt_ff[AW:0];
   end
   // state and pointers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff        <= ST_IDLE;
         base_ff      <= '0;
         off_ff       <= '0;
         seg_ff       <= '0;
         post_left_ff <= '0;
         sidx_ff      <= '0;
         nseg_ff      <= '0;
      end else if (arm) begin                       // new run starts clean
         st_ff   <= ST_PRE;
         base_ff <= '0;
         off_ff  <= '0;
         sidx_ff <= '0;
         nseg_ff <= '0;
         seg_ff  <= MULTI ? spt_clamp : (AW+1)'(DEPTH);
      end else if (abort) begin
         st_ff <= ST_END;
      end else if (seg_end) begin                   // segment complete
         nseg_ff <= nseg_ff + CNT_W'(1);
         off_ff  <= '0;
         sidx_ff <= '0;
         if (last_seg) st_ff <= ST_END;
         else begin
            st_ff   <= ST_PRE;
            base_ff <= base_ff + seg_ff;
         end
      end else if (smp_stb && run) begin
         if (store) begin
            off_ff  <= (off_ff == seg_ff - 1'b1) ? '0 : off_ff + 1'b1;
            sidx_ff <= sidx_ff + 1'b1;
         end
         if (st_ff == ST_PRE && hit) begin          // trigger seen
            st_ff        <= ST_POST;
            post_left_ff <= (post_ff > 32'(seg_ff - 1'b1)) ? seg_ff - 1'b1 : post_ff[AW:0];
         end else if (st_ff == ST_POST && store) begin
            post_left_ff <= post_left_ff - 1'b1;
         end
      end
   end
   // trigger position per segment
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NSEG; i++) begin
            tpos_ff[i] <= '0;
            tapx_ff[i] <= 1'b0;
         end
      end else if (smp_stb && st_ff == ST_PRE && hit && !arm && !abort) begin
         tpos_ff[int'(nseg_ff) % NSEG] <= (AW+1)'(waddr);
         tapx_ff[int'(nseg_ff) % NSEG] <= !en_ok;
      end
   end
   // timestamp, counts every sample cycle of the run
   always_ff @(posedge clk_i) begin
      if (rst_i || arm) ts_ff <= '0;
      else if (smp_stb && run) ts_ff <= ts_ff + 1'b1;
   end
   // trace buffer
   always_ff @(posedge clk_i) begin
      if (store && !arm && !abort) mem[waddr] <= word;
   end

   // read side
   logic [WP-1:0] rd_word;                          // addressed sample, padded
   logic [31:0]   rd_mux;                           // data of addressed register
   logic [31:0]   tpos_q;                           // addressed trigger position
   always_comb begin
      rd_word = WP'(mem[AW'(rdadr_ff)]);
      tpos_q  = 32'(tpos_ff[int'(rdadr_ff) % NSEG]);
      tpos_q[TPOS_APPROX] = tapx_ff[int'(rdadr_ff) % NSEG];
      rd_mux  = '0;
      unique case (adr_i)
         REG_CTRL:   rd_mux = 32'({st_ff == ST_POST, MULTI, st_ff == ST_END, run});
         REG_SPT:    rd_mux = spt_ff;
         REG_POST:   rd_mux = post_ff;
         REG_TU_EN:  rd_mux = tuen_ff;
         REG_TU_SEL: rd_mux = tusel_ff;
         REG_TU_OP:  rd_mux = (int'(sel_unit) < NUM_TU) ? 32'(op_ff[int'(sel_unit) % NUM_TU]) : '0;
         REG_TU_VAL: rd_mux = (int'(sel_unit) < NUM_TU && int'(sel_word) < VP/32) ?
                              val_ff[int'(sel_unit) % NUM_TU][sel_word*32 +: 32] : '0;
         REG_RD_ADR: rd_mux = rdadr_ff;
         REG_RD_WSL: rd_mux = rdwsl_ff;
         REG_RD_DAT: rd_mux = (int'(rdwsl_ff[WSEL_W-1:0]) < WP/32) ?
                              rd_word[rdwsl_ff[WSEL_W-1:0]*32 +: 32] : '0;
         REG_TPOS:   rd_mux = tpos_q;
         REG_CNT:    rd_mux = {CNT_W'(sidx_ff), nseg_ff};
         REG_TS:     rd_mux = 32'(ts_ff);
         default:    rd_mux = '0;                   // unmapped reads as zero
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) dat_o <= '0;
      else if (req && !we_i) dat_o <= rd_mux;
   end

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;   cyc_i && stb_i && !ack_ff; endsequence
   sequence s_ack;   ack_o ##1 !ack_o;          endsequence
   property p_ack;   s_req |=> s_ack; endproperty
   a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
   property p_depth; (DEPTH >= DEPTH_MIN) && (DEPTH <= DEPTH_MAX) && ((DEPTH & (DEPTH-1)) == 0); endproperty
   a_depth: assert property (p_depth) else $error("buffer depth illegal");
   property p_one_rise; smp_stb |=> !smp_stb; endproperty
   a_one_rise: assert property (p_one_rise) else $error("two samples in a row");
   property p_no_store; smp_stb && run && !en_ok && !arm && !seg_end |=> $stable(sidx_ff); endproperty
   a_no_store: assert property (p_no_store) else $error("sample stored with enable idle");
   property p_ts; smp_stb && run && !arm |=> ts_ff == $past(ts_ff) + 1'b1; endproperty
   a_ts: assert property (p_ts) else $error("timestamp did not advance");
   property p_word; store && !arm && !abort |=> mem[$past(waddr)] == $past(word); endproperty
   a_word: assert property (p_word) else $error("stored word mismatch");
   property p_stop; st_ff == ST_END && !arm |=> st_ff == ST_END && !store; endproperty
   a_stop: assert property (p_stop) else $error("capture resumed without arm");
   property p_seg; run |-> (!MULTI || seg_ff >= MIN_L); endproperty
   a_seg: assert property (p_seg) else $error("segment below minimum");
   property p_apx; smp_stb && st_ff == ST_PRE && hit && !arm && !abort
                   |=> tapx_ff[int'($past(nseg_ff)) % NSEG] == !$past(en_ok) && st_ff == ST_POST; endproperty
   a_apx: assert property (p_apx) else $error("trigger position flag wrong");
endmodule // etc_core
`default_nettype wire

// *** hw/etc_pkg.sv ***
// constants, types and register map of the embedded trace capture core
package etc_pkg;
   localparam int WB_AW = 8;                        // byte address width
   localparam int WB_DW = 32;                       // data width
   localparam int WB_SW = 4;                        // byte select width
   // register byte offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;       // w: arm/abort, r: status
   localparam logic [7:0] REG_SPT    = 8'h04;       // samples per trigger
   localparam logic [7:0] REG_POST   = 8'h08;       // samples kept after trigger
   localparam logic [7:0] REG_TU_EN  = 8'h0C;       // trigger unit enable mask
   localparam logic [7:0] REG_TU_SEL = 8'h10;       // unit and value word select
   localparam logic [7:0] REG_TU_OP  = 8'h14;       // operator of selected unit
   localparam logic [7:0] REG_TU_VAL = 8'h18;       // value word of selected unit
   localparam logic [7:0] REG_RD_ADR = 8'h1C;       // sample / segment index
   localparam logic [7:0] REG_RD_WSL = 8'h20;       // word within sample
   localparam logic [7:0] REG_RD_DAT = 8'h24;       // selected sample word
   localparam logic [7:0] REG_TPOS   = 8'h28;       // trigger position of segment
   localparam logic [7:0] REG_CNT    = 8'h2C;       // segments and sample index
   localparam logic [7:0] REG_TS     = 8'h30;       // live timestamp
   // field positions
   localparam int CTRL_ARM    = 0;                  // write 1 starts a run
   localparam int CTRL_ABORT  = 1;                  // write 1 ends a run
   localparam int ST_RUN      = 0;                  // run in progress
   localparam int ST_DONE     = 1;                  // capture complete
   localparam int ST_MULTI    = 2;                  // built for multiple triggers
   localparam int ST_TRIG     = 3;                  // waiting for post samples
   localparam int SEL_WORD_LSB = 8;                 // tu_sel word field
   localparam int SEL_W       = 4;                  // width of each tu_sel field
   localparam int TPOS_APPROX = 31;                 // position only approximate
   localparam int CNT_IDX_LSB = 16;                 // sample index field
   localparam int CNT_W       = 16;                 // width of count fields
   localparam int WSEL_W      = 8;                  // word select width
   // limits
   localparam int DEPTH_MIN   = 16;
   localparam int DEPTH_MAX   = 65536;
   localparam int TRACE_MAX   = 512;
   localparam int TU_MAX      = 16;
   localparam int TU_W_MAX    = 256;
   localparam int TRIG_WIN    = 5;                  // approx trigger region, cycles
   localparam int SMP_MAX_MHZ = 200;                // advised sample clock ceiling
   // comparison operators
   localparam int OPW = 4;
   typedef enum logic [3:0] {
      OP_EQ   = 4'h0,
      OP_NE   = 4'h1,
      OP_GT   = 4'h2,
      OP_GE   = 4'h3,
      OP_LT   = 4'h4,
      OP_LE   = 4'h5,
      OP_RISE = 4'h6,
      OP_FALL = 4'h7,
      OP_SER  = 4'h8
   } etc_op_t;
   // capture state
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PRE  = 2'b01,
      ST_POST = 2'b10,
      ST_END  = 2'b11
   } etc_st_t;
endpackage : etc_pkg

// *** hw/etc_trig_unit.sv ***
// one trigger unit: compares its signal group with a run-time value
`timescale 1ns/1ns
`default_nettype none
module etc_trig_unit #(
   parameter int W       = 8,                       // signals in this unit
   parameter int SER_LEN = 4                        // serial pattern length
) (
   input  wire logic             clk_i,             // core clock
   input  wire logic             rst_i,             // synchronous reset
   input  wire logic             smp_stb_i,         // one cycle per sample rise
   input  wire logic [W-1:0]     sig_i,             // current combined value
   input  wire etc_pkg::etc_op_t op_i,              // operator
   input  wire logic [W-1:0]     val_i,             // value or edge mask
   output logic                  hit_o              // unit is true this sample
);
   import etc_pkg::*;
   logic [W-1:0]         prev_ff;                   // previous sample
   logic [SER_LEN-2:0]   ser_ff;                    // earlier bits of serial signal
   logic [SER_LEN-1:0]   ser_win;                   // window, oldest bit on top
   assign ser_win = {ser_ff, sig_i[0]};
   // history, advanced once per sample
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_ff <= '0;
         ser_ff  <= '0;
      end else if (smp_stb_i) begin
         prev_ff <= sig_i;
         ser_ff  <= ser_win[SER_LEN-2:0];
      end
   end
   // comparison, op and value come from live registers
   always_comb begin
      hit_o = 1'b0;
      unique case (op_i)
         OP_EQ:   hit_o = (sig_i == val_i);
         OP_NE:   hit_o = (sig_i != val_i);
         OP_GT:   hit_o = (sig_i >  val_i);
         OP_GE:   hit_o = (sig_i >= val_i);
         OP_LT:   hit_o = (sig_i <  val_i);
         OP_LE:   hit_o = (sig_i <= val_i);
         OP_RISE: hit_o = |(val_i & sig_i & ~prev_ff);
         OP_FALL: hit_o = |(val_i & ~sig_i & prev_ff);
         OP_SER:  hit_o = (ser_win == val_i[SER_LEN-1:0]);
         default: hit_o = 1'b0;                     // unused codes never hit
      endcase
   end
endmodule // etc_trig_unit
`default_nettype wire

// *** tb/etc_link_model.sv ***
// sample-side partner: free sample clock, counting trace
`timescale 1ns/1ns
`default_nettype none
module etc_link_model (
   input  wire logic        sen_on_i,  // enable level wanted
   output logic             smp_clk_o, // sample clock
   output logic             sen_o,     // sample enable
   output logic [31:0]      trace_o,   // traced signals
   output logic [15:0]      trig_o     // unit signals
);
   // free-running sample clock, slower than core clock; one process drives clock and data
   initial begin
      smp_clk_o = 1'b0;
      trace_o   = 32'h0;
      forever begin
         #80 smp_clk_o = 1'b1;
         #80 smp_clk_o = 1'b0;
         trace_o = trace_o + 32'h1; // data moves on the fall so it is settled at the rise
      end
   end
   assign trig_o = {trace_o[15:8], trace_o[7:0]}; // unit 0 sees low byte
   assign sen_o  = sen_on_i;
endmodule // etc_link_model
`default_nettype wire

// *** tb/etc_core_test.sv ***
// register-level test of the trace capture core
`timescale 1ns/1ns
`default_nettype none
module etc_core_test;
   import etc_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, sen_on = 1;
   logic [7:0]  adr_i = 0;
   logic [3:0]  sel_i = 0;
   logic [31:0] dat_i = 0, dat_o, trace_i, rd, tp;
   logic        ack_o, smp_clk_i, sen_i;
   logic [15:0] trig_i;
   int miscompares = 0, comparisons = 0, cycles = 0, n;
   etc_core dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .smp_clk_i(smp_clk_i), .sen_i(sen_i),
      .trace_i(trace_i), .trig_i(trig_i));
   etc_link_model link (.sen_on_i(sen_on), .smp_clk_o(smp_clk_i), .sen_o(sen_i), .trace_o(trace_i),
      .trig_o(trig_i));
   // 50 mhz core clock
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   // one bus cycle; held until ack is seen
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hF};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      {cyc_i, stb_i, we_i} <= 3'b000;
   endtask
   // compare under a mask
   task automatic chk(input string nm, input logic [31:0] m, input logic [31:0] e);
      comparisons++;
      if ((rd & m) !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, rd & m);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // hang guard
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         miscompares++;
         conclude();
      end
   end
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(0, REG_CTRL, 0); chk("status", 32'hF, 32'h4);
      bus(0, REG_SPT, 0); chk("spt", 32'hFFFF, 32'd16);
      bus(0, 8'h3C, 0); chk("unmapped", '1, 0);
      bus(1, REG_SPT, 16);
      bus(1, REG_POST, 4);
      bus(1, REG_TU_SEL, 0);
      bus(1, REG_TU_OP, OP_EQ);
      bus(1, REG_TU_VAL, 32'h20);
      bus(1, REG_TU_EN, 1);
      bus(1, REG_CTRL, 1);
      n = 0;
      do begin bus(0, REG_CTRL, 0); n++; end while (rd[ST_DONE] !== 1'b1 && n < 9000);
      bus(0, REG_CNT, 0); chk("segments", 32'hFFFF, 32'd4);
      bus(1, REG_RD_ADR, 0);
      bus(0, REG_TPOS, 0); tp = rd; chk("tpos exact", 32'h8000_0000, 0);
      bus(1, REG_RD_ADR, tp & 32'hFFFF);
      bus(1, REG_RD_WSL, 0);
      bus(0, REG_RD_DAT, 0); chk("trig trace", 32'hFF, 32'h20);
      bus(1, REG_RD_WSL, 1);
      bus(0, REG_RD_DAT, 0); chk("trig bits", 32'hFF, 32'h20);
      sen_on <= 1'b0;
      bus(1, REG_CTRL, 1);
      repeat (400) @(posedge clk_i);
      bus(0, REG_CNT, 0); chk("no store", 32'hFFFF_0000, 0);
      bus(0, REG_TS, 0); chk("ts runs", 32'hFFF0, 32'h0030);
      bus(0, REG_TS, 0); tp = rd;
      // 77 idle cycles plus the bus cycles put 80 clocks, ten sample periods, between captures
      repeat (77) @(posedge clk_i);
      bus(0, REG_TS, 0); chk("ts moved", '1, tp + 32'd10);
      bus(1, REG_CTRL, 2);
      bus(0, REG_CTRL, 0); chk("aborted", 32'h3, 32'h2);
      // rising-edge trigger on bit 7 of unit 0, enable active again
      sen_on <= 1'b1;
      bus(1, REG_TU_OP, OP_RISE);
      bus(0, REG_TU_OP, 0); chk("op back", 32'hF, 32'h6);
      bus(1, REG_TU_VAL, 32'h80);
      bus(1, REG_CTRL, 1);
      n = 0;
      do begin bus(0, REG_CTRL, 0); n++; end while (rd[ST_DONE] !== 1'b1 && n < 9000);
      bus(1, REG_RD_ADR, 1);
      bus(0, REG_TPOS, 0); tp = rd; chk("tpos seg1", 32'h70, 32'h10);
      bus(1, REG_RD_ADR, tp & 32'hFFFF);
      bus(1, REG_RD_WSL, 0);
      bus(0, REG_RD_DAT, 0); chk("rise trace", 32'hFF, 32'h80);
      conclude();
   end
endmodule // etc_core_test
`default_nettype wire
